// *** shared/dmb_pkg.sv ***
// Purpose: shared constants and carriers for the dual-master bus control block
// Assumes: management clock of 25 MHz; link-side byte engines feed decoded commands
// Notes:   times are in milliseconds, cycle counts derive from the clock rate
package dmb_pkg;

  // command codes seen on either management bus
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_CLAIM_CTL    = 8'hd8;
  localparam logic [7:0] REG_OWN_STATUS   = 8'hd7;

  // ownership status layout, bus 1 in the high nibble
  localparam int         OWN_BIT_HAS_CTL = 0;
  localparam int         OWN_BIT_REQ     = 1;
  localparam int         OWN_BIT_ALERT   = 2;
  localparam int         OWN_BIT_ERR     = 3;
  localparam int         OWN_BUS_STRIDE  = 4;
  localparam logic [7:0] OWN_RESET       = 8'h01;

  // timing figures
  localparam int unsigned MCLK_KHZ     = 25000;
  localparam int unsigned T_RETRY_MS   = 1000;
  localparam int unsigned T_HOLD_MS    = 2000;
  localparam int unsigned T_WINDOW_MS  = 60000;
  localparam int unsigned T_ADDR_MS    = 15000;
  localparam int unsigned RETRY_CYC    = T_RETRY_MS * MCLK_KHZ;
  localparam int unsigned HOLD_CYC     = T_HOLD_MS * MCLK_KHZ;
  localparam int unsigned WINDOW_CYC   = T_WINDOW_MS * MCLK_KHZ;
  localparam int unsigned ADDR_CYC     = T_ADDR_MS * MCLK_KHZ;
  localparam logic [1:0]  OV_STRIKES   = 2'd3;

  // bus voltage figures, millivolts
  localparam logic [15:0] BUS_V_LOW_MV = 16'd40000;

  // unresolved address keeps the low nibble at zero
  localparam logic [6:0]  ADDR_DFLT_MASK = 7'h70;

  // one completed write command from a byte engine
  typedef struct packed {
    logic [7:0] code;
    logic       pec_ok;
  } dmb_txn_s;

  // live power-stage condition, same clock as this block
  typedef struct packed {
    logic ov_trip;
    logic oc_trip;
    logic ot_trip;
    logic oc_latch_cfg;
    logic ot_latch_cfg;
    logic op_off;
    logic back_biased;
    logic final_state;
  } dmb_stage_s;

  typedef enum logic [2:0] {
    PWR_CHECK = 3'b000,
    PWR_ON    = 3'b001,
    PWR_RETRY = 3'b011,
    PWR_LATCH = 3'b010,
    PWR_HOLD  = 3'b110,
    PWR_WAITV = 3'b111
  } dmb_pwr_e;

endpackage

// *** hdl/dmb_ctrl.sv ***
// Purpose: ownership, alert, fault capture and restart control for two bus masters
// Assumes: link byte engines run on lclk and hold a command until cmd_ready
// Notes:   ownership state returns to default only on nrst (bias loss)
module dmb_ctrl #(
  parameter int unsigned RETRY_CYC  = dmb_pkg::RETRY_CYC,
  parameter int unsigned HOLD_CYC   = dmb_pkg::HOLD_CYC,
  parameter int unsigned WINDOW_CYC = dmb_pkg::WINDOW_CYC,
  parameter int unsigned ADDR_CYC   = dmb_pkg::ADDR_CYC,
  parameter int          FAULT_W    = 8,
  parameter int          OPST_W     = 8
) (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   lclk,
  input  wire dmb_pkg::dmb_txn_s [1:0] cmd_txn,
  input  wire logic [1:0]             cmd_stb,
  output logic [1:0]                  cmd_ready,
  input  wire logic [1:0]             wr_active,
  output logic [7:0]                  own_status_rd,
  input  wire logic                   on_off_n,
  input  wire logic                   module_present,
  input  wire logic                   input_ok,
  input  wire dmb_pkg::dmb_stage_s     stage,
  input  wire logic [FAULT_W-1:0]     fault_live,
  input  wire logic [OPST_W-1:0]      opst_live,
  input  wire logic [15:0]            bus_v_mv,
  input  wire logic [15:0]            set_v_mv,
  input  wire logic                   host_v_set,
  input  wire logic [6:0]             addr_sel,
  output logic [6:0]                  dev_addr,
  output logic                        addr_resolved,
  output logic [1:0]                  alert_o,
  output logic [1:0]                  alert_oe,
  output logic                        out_en,
  output logic                        restart_ok,
  output logic [FAULT_W-1:0]          fault_reg,
  output logic                        cmd_valid,
  output logic                        cmd_bus,
  output logic [7:0]                  cmd_code
);

  typedef struct packed {
    dmb_pkg::dmb_txn_s [1:0] rec;
    logic [1:0]              req_tgl;
    logic [1:0]              ack_s1;
    logic [1:0]              ack_s2;
    logic                    snp_s1;
    logic                    snp_s2;
    logic                    snp_seen;
    logic [7:0]              stat;
  } dmb_link_s;

  typedef struct packed {
    logic [1:0]          req_s1;
    logic [1:0]          req_s2;
    logic [1:0]          req_seen;
    logic [1:0]          wrb_s1;
    logic [1:0]          wrb_s2;
    logic [2:0]          pin_s1;
    logic [2:0]          pin_s2;
    logic [2:0]          pin_d;
    logic                own;
    logic [1:0]          req_ctl;
    logic [1:0]          cmd_err;
    logic [1:0]          alert_sel;
    logic                dev_alert;
    logic [FAULT_W-1:0]  fault_reg;
    logic [OPST_W-1:0]   opst_prev;
    logic                primed;
    logic                restart_ok;
    logic                restarting;
    logic [7:0]          snap;
    logic                snap_tgl;
    logic                ackb_s1;
    logic                ackb_s2;
    dmb_pkg::dmb_pwr_e   pwr;
    logic [31:0]         tmr;
    logic [31:0]         win;
    logic [1:0]          ov_cnt;
    logic [2:0]          trip_d;
    logic [1:0]          latch_src;
    logic [31:0]         addr_tmr;
    logic                addr_ok;
    logic                out_en;
    logic                cmd_valid;
    logic                cmd_bus;
    logic [7:0]          cmd_code;
  } dmb_main_s;

  logic [1:0] mrst_q;
  logic [1:0] lrst_q;
  logic       mrst_n;
  logic       lrst_n;
  dmb_link_s  lk;
  dmb_link_s  next_lk;
  dmb_main_s  s;
  dmb_main_s  next_s;

  function automatic logic [31:0] sat_dec(input logic [31:0] v);
    sat_dec = (v == 32'h0) ? 32'h0 : v - 32'h1;
  endfunction

  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction

  // ownership status byte from main-domain state
  function automatic logic [7:0] own_byte(input dmb_main_s m);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 2; i++)
    begin
      b[i*dmb_pkg::OWN_BUS_STRIDE + dmb_pkg::OWN_BIT_HAS_CTL] = (m.own == i[0]);
      b[i*dmb_pkg::OWN_BUS_STRIDE + dmb_pkg::OWN_BIT_REQ]     = m.req_ctl[i];
      b[i*dmb_pkg::OWN_BUS_STRIDE + dmb_pkg::OWN_BIT_ALERT]   = m.alert_sel[i] | m.dev_alert;
      b[i*dmb_pkg::OWN_BUS_STRIDE + dmb_pkg::OWN_BIT_ERR]     = m.cmd_err[i];
    end
    own_byte = b;
  endfunction

  // reset release synchronisers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      mrst_q <= 2'b00;
    else
      mrst_q <= {mrst_q[0], 1'b1};
  end

  always_ff @(posedge lclk or negedge nrst)
  begin
    if (!nrst)
      lrst_q <= 2'b00;
    else
      lrst_q <= {lrst_q[0], 1'b1};
  end

  assign mrst_n = mrst_q[1];
  assign lrst_n = lrst_q[1];

  // link domain: command capture and status mirror
  always_comb
  begin
    next_lk        = lk;
    next_lk.ack_s1 = s.req_seen;
    next_lk.ack_s2 = lk.ack_s1;
    next_lk.snp_s1 = s.snap_tgl;
    next_lk.snp_s2 = lk.snp_s1;
    for (int b = 0; b < 2; b++)
    begin
      if (cmd_stb[b] && (lk.req_tgl[b] == lk.ack_s2[b]))
      begin
        next_lk.rec[b]     = cmd_txn[b];
        next_lk.req_tgl[b] = ~lk.req_tgl[b];
      end
    end
    if (lk.snp_s2 != lk.snp_seen)
    begin
      next_lk.stat     = s.snap;
      next_lk.snp_seen = lk.snp_s2;
    end
  end

  always_ff @(posedge lclk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      lk      <= '0;
      lk.stat <= dmb_pkg::OWN_RESET;
    end
    else
      lk <= next_lk;
  end

  assign cmd_ready     = ~(lk.req_tgl ^ lk.ack_s2);
  assign own_status_rd = lk.stat;

  // main domain
  always_comb
  begin
    logic       ev;
    logic       clr_own;
    logic       off_req;
    logic [2:0] trips;
    logic       new_bits;
    logic [1:0] nxt_ov;
    ev       = 1'b0;
    clr_own  = 1'b0;
    off_req  = 1'b0;
    trips    = 3'b000;
    new_bits = 1'b0;
    nxt_ov   = 2'b00;
    next_s   = s;

    next_s.req_s1    = lk.req_tgl;
    next_s.req_s2    = s.req_s1;
    next_s.wrb_s1    = wr_active;
    next_s.wrb_s2    = s.wrb_s1;
    next_s.pin_s1    = {on_off_n, module_present, input_ok};
    next_s.pin_s2    = s.pin_s1;
    next_s.pin_d     = s.pin_s2;
    next_s.ackb_s1   = lk.snp_seen;
    next_s.ackb_s2   = s.ackb_s1;
    next_s.cmd_valid = 1'b0;

    // decoded commands from both buses
    for (int b = 0; b < 2; b++)
    begin
      if (s.req_s2[b] != s.req_seen[b])
      begin
        next_s.req_seen[b] = s.req_s2[b];
        if (!lk.rec[b].pec_ok)
          next_s.cmd_err[b] = 1'b1;
        else if (lk.rec[b].code == dmb_pkg::CMD_CLAIM_CTL)
        begin
          if (s.own != b[0])
            next_s.req_ctl[b] = 1'b1;
        end
        else if (lk.rec[b].code == dmb_pkg::CMD_CLEAR_FAULTS)
        begin
          next_s.alert_sel[b] = 1'b0;
          next_s.cmd_err[b]   = 1'b0;
          if (s.own == b[0])
            clr_own = 1'b1;
        end
        else if (s.own == b[0])
        begin
          next_s.cmd_valid = 1'b1;
          next_s.cmd_bus   = b[0];
          next_s.cmd_code  = lk.rec[b].code;
        end
        else
          next_s.cmd_err[b] = 1'b1;
      end
    end

    // handover once the owner has no write in flight
    if (s.req_ctl[~s.own] && !s.wrb_s2[s.own] &&
        (s.ackb_s2 == s.snap_tgl) && (s.snap == own_byte(s)))
    begin
      next_s.own       = ~s.own;
      next_s.req_ctl   = 2'b00;
      next_s.alert_sel = 2'b11;
    end

    // fault capture at final state only
    if (clr_own)
    begin
      next_s.fault_reg  = stage.final_state ? fault_live : '0;
      next_s.restart_ok = 1'b0;
      next_s.dev_alert  = 1'b0;
    end
    else if (stage.final_state)
      next_s.fault_reg = s.fault_reg | fault_live;
    new_bits = (|(next_s.fault_reg & ~s.fault_reg)) && !clr_own;
    next_s.opst_prev = opst_live;
    next_s.primed    = 1'b1;

    // state-change notifications, none from the reset value of opst_prev
    if (new_bits || (s.primed && (opst_live != s.opst_prev)))
      ev = 1'b1;
    if (rise(s.pin_s2[0], s.pin_d[0]) && !stage.back_biased)
      ev = 1'b1;
    if (rise(s.pin_s2[1], s.pin_d[1]))
      ev = 1'b1;

    // address settling after insertion
    if (rise(s.pin_s2[1], s.pin_d[1]))
    begin
      next_s.addr_ok  = 1'b0;
      next_s.addr_tmr = 32'(ADDR_CYC);
    end
    else if (!s.addr_ok)
    begin
      next_s.addr_tmr = sat_dec(s.addr_tmr);
      if (s.addr_tmr == 32'h0)
        next_s.addr_ok = 1'b1;
    end

    // power sequencing
    off_req = !s.pin_s2[2] || !s.pin_s2[1] || !s.pin_s2[0] || stage.op_off;
    trips   = {stage.ov_trip, stage.oc_trip, stage.ot_trip};
    next_s.trip_d = trips;
    nxt_ov  = s.ov_cnt;
    if (s.ov_cnt != 2'b00)
    begin
      next_s.win = sat_dec(s.win);
      if (s.win == 32'h0)
        nxt_ov = 2'b00;
    end
    next_s.tmr = sat_dec(s.tmr);

    case (s.pwr)
      dmb_pkg::PWR_CHECK:
      begin
        next_s.out_en = 1'b0;
        if (!off_req)
        begin
          if ((bus_v_mv < dmb_pkg::BUS_V_LOW_MV) || (bus_v_mv == set_v_mv))
            next_s.pwr = dmb_pkg::PWR_ON;
          else
            next_s.pwr = dmb_pkg::PWR_WAITV;
        end
      end
      dmb_pkg::PWR_WAITV:
      begin
        next_s.out_en = 1'b0;
        if (off_req)
          next_s.pwr = dmb_pkg::PWR_CHECK;
        else if (host_v_set)
          next_s.pwr = dmb_pkg::PWR_ON;
      end
      dmb_pkg::PWR_ON:
      begin
        next_s.out_en = 1'b1;
        if (s.restarting && s.out_en)
        begin
          next_s.restarting = 1'b0;
          next_s.restart_ok = 1'b1;
          next_s.fault_reg  = '0;
        end
        if (rise(trips[2], s.trip_d[2]))
        begin
          next_s.out_en = 1'b0;
          if ((s.ov_cnt == 2'b00) || (s.win == 32'h0))
            next_s.win = 32'(WINDOW_CYC);
          nxt_ov = (s.win == 32'h0 && s.ov_cnt != 2'b00) ? 2'b01 : s.ov_cnt + 2'b01;
          if (nxt_ov == dmb_pkg::OV_STRIKES)
          begin
            next_s.pwr       = dmb_pkg::PWR_LATCH;
            next_s.latch_src = 2'b00;
            nxt_ov           = 2'b00;
          end
          else
          begin
            next_s.pwr = dmb_pkg::PWR_RETRY;
            next_s.tmr = 32'(RETRY_CYC);
          end
        end
        else if (rise(trips[1], s.trip_d[1]) || rise(trips[0], s.trip_d[0]))
        begin
          next_s.out_en = 1'b0;
          if ((trips[1] && stage.oc_latch_cfg) || (trips[0] && stage.ot_latch_cfg))
          begin
            next_s.pwr       = dmb_pkg::PWR_LATCH;
            next_s.latch_src = {trips[1], trips[0]};
          end
          else
          begin
            next_s.pwr = dmb_pkg::PWR_RETRY;
            next_s.tmr = 32'(RETRY_CYC);
          end
        end
        else if (off_req)
        begin
          next_s.out_en = 1'b0;
          next_s.pwr    = dmb_pkg::PWR_CHECK;
        end
      end
      dmb_pkg::PWR_RETRY:
      begin
        next_s.out_en = 1'b0;
        if (s.tmr == 32'h0)
        begin
          next_s.pwr        = dmb_pkg::PWR_CHECK;
          next_s.restarting = 1'b1;
        end
      end
      dmb_pkg::PWR_LATCH:
      begin
        next_s.out_en = 1'b0;
        nxt_ov        = 2'b00;
        if ((s.latch_src[1] && !stage.oc_latch_cfg) || (s.latch_src[0] && !stage.ot_latch_cfg))
        begin
          next_s.pwr        = dmb_pkg::PWR_CHECK;
          next_s.restarting = 1'b1;
        end
        else if (off_req)
        begin
          next_s.pwr = dmb_pkg::PWR_HOLD;
          next_s.tmr = 32'(HOLD_CYC);
        end
      end
      dmb_pkg::PWR_HOLD:
      begin
        next_s.out_en = 1'b0;
        nxt_ov        = 2'b00;
        if (!off_req)
        begin
          if (s.tmr == 32'h0)
          begin
            next_s.pwr        = dmb_pkg::PWR_CHECK;
            next_s.restarting = 1'b1;
          end
          else
            next_s.pwr = dmb_pkg::PWR_LATCH;
        end
      end
      default:
      begin
        next_s.out_en = 1'b0;
        next_s.pwr    = dmb_pkg::PWR_CHECK;
      end
    endcase
    next_s.ov_cnt = nxt_ov;

    if (ev)
      next_s.dev_alert = 1'b1;

    // status mirror toward the link side
    if ((s.ackb_s2 == s.snap_tgl) && (own_byte(s) != s.snap))
    begin
      next_s.snap     = own_byte(s);
      next_s.snap_tgl = ~s.snap_tgl;
    end
  end

  always_ff @(posedge mclk or negedge mrst_n)
  begin
    if (!mrst_n)
    begin
      s      <= '0;
      s.snap <= dmb_pkg::OWN_RESET;
      s.pwr  <= dmb_pkg::PWR_CHECK;
    end
    else
      s <= next_s;
  end

  assign alert_o       = 2'b00;
  assign alert_oe      = s.alert_sel | {2{s.dev_alert}};
  assign out_en        = s.out_en;
  assign restart_ok    = s.restart_ok;
  assign fault_reg     = s.fault_reg;
  assign cmd_valid     = s.cmd_valid;
  assign cmd_bus       = s.cmd_bus;
  assign cmd_code      = s.cmd_code;
  assign addr_resolved = s.addr_ok;
  assign dev_addr      = s.addr_ok ? addr_sel : (addr_sel & dmb_pkg::ADDR_DFLT_MASK);

endmodule // dmb_ctrl

// *** testbench/dmb_ctrl_sva.sv ***
// Purpose: port checker for the dual-master control block
// Assumes: sees only the top module ports
// Notes:   bound to every instance of the block
module dmb_ctrl_sva #(
  parameter int FAULT_W = 8
) (
  input wire logic                mclk,
  input wire logic                nrst,
  input wire logic                lclk,
  input wire logic [1:0]          cmd_stb,
  input wire logic [1:0]          cmd_ready,
  input wire logic [7:0]          own_status_rd,
  input wire dmb_pkg::dmb_stage_s stage,
  input wire logic [6:0]          addr_sel,
  input wire logic [6:0]          dev_addr,
  input wire logic                addr_resolved,
  input wire logic [1:0]          alert_o,
  input wire logic                out_en,
  input wire logic                restart_ok,
  input wire logic [FAULT_W-1:0]  fault_reg
);
  timeunit 1ns;
  timeprecision 100ps;
  AST_ALERT_LOW: assert property (
    @(posedge mclk) disable iff (!nrst) alert_o == 2'b00)
    else $error("alert data high");
  AST_ADDR: assert property (
    @(posedge mclk) disable iff (!nrst)
    dev_addr == (addr_resolved ? addr_sel : (addr_sel & dmb_pkg::ADDR_DFLT_MASK)))
    else $error("device address wrong");
  AST_OWN_ONE: assert property (
    @(posedge lclk) disable iff (!nrst) $onehot({own_status_rd[4], own_status_rd[0]}))
    else $error("owner not unique");
  AST_OWN_MOVE: assert property (
    @(posedge lclk) disable iff (!nrst)
    $changed(own_status_rd[4]) |-> $past(own_status_rd[5]) || $past(own_status_rd[1]))
    else $error("owner moved unrequested");
  AST_HANDOVER_ALERT: assert property (
    @(posedge lclk) disable iff (!nrst)
    $changed(own_status_rd[4]) |-> own_status_rd[6] && own_status_rd[2])
    else $error("handover without alert");
  AST_RESTART_CLR: assert property (
    @(posedge mclk) disable iff (!nrst) $rose(restart_ok) |-> fault_reg == '0)
    else $error("restart left alarms");
  AST_OV_OFF: assert property (
    @(posedge mclk) disable iff (!nrst) $rose(stage.ov_trip) |-> ##[1:4] !out_en)
    else $error("output stayed on");
  AST_TAKE0: assert property (
    @(posedge lclk) disable iff (!nrst) cmd_stb[0] && cmd_ready[0] |=> !cmd_ready[0])
    else $error("bus 0 slot stayed free");
  AST_TAKE1: assert property (
    @(posedge lclk) disable iff (!nrst) cmd_stb[1] && cmd_ready[1] |=> !cmd_ready[1])
    else $error("bus 1 slot stayed free");
endmodule // dmb_ctrl_sva

bind dmb_ctrl dmb_ctrl_sva #(.FAULT_W(FAULT_W)) dmb_ctrl_sva_inst (
  .mclk(mclk), .nrst(nrst), .lclk(lclk), .cmd_stb(cmd_stb), .cmd_ready(cmd_ready),
  .own_status_rd(own_status_rd), .stage(stage), .addr_sel(addr_sel), .dev_addr(dev_addr),
  .addr_resolved(addr_resolved), .alert_o(alert_o), .out_en(out_en),
  .restart_ok(restart_ok), .fault_reg(fault_reg));

// *** testbench/dmb_host_model.sv ***
// Purpose: two system controllers feeding completed commands
// Assumes: requests change just after an lclk edge
// Notes:   released command fields show the inverse of the last value
module dmb_host_model (
  input  wire logic               lclk,
  input  wire logic [1:0]         cmd_ready,
  output dmb_pkg::dmb_txn_s [1:0] cmd_txn,
  output logic [1:0]              cmd_stb,
  output logic [1:0]              wr_active
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] hold_wr;
  int         timeouts;
  initial
  begin
    cmd_txn = '0;
    cmd_stb = '0;
    wr_active = '0;
    hold_wr = '0;
    timeouts = 0;
  end
  // keep a write open on bus b
  task automatic hold_write(input int b, input logic on);
    @(posedge lclk);
    hold_wr[b] <= on;
    wr_active[b] <= on;
  endtask
  // one write transaction, start to stop
  task automatic send(input int b, input logic [7:0] code, input logic pec_ok);
    int n;
    n = 0;
    @(posedge lclk);
    wr_active[b] <= 1'b1;
    cmd_txn[b] <= '{code: code, pec_ok: pec_ok};
    cmd_stb[b] <= 1'b1;
    do
    begin
      @(posedge lclk);
      n++;
    end
    while (!cmd_ready[b] && n < 200);
    if (!cmd_ready[b])
      timeouts++;
    cmd_stb[b] <= 1'b0;
    cmd_txn[b] <= ~cmd_txn[b];
    wr_active[b] <= hold_wr[b];
  endtask
endmodule // dmb_host_model

// *** testbench/dmb_ctrl_tb_top.sv ***
// Purpose: self-checking bench for the dual-master control block
// Assumes: shortened timing parameters, link clock 6 ns
// Notes:   random values from a fixed seed
module dmb_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RETRY = 20;
  localparam int HOLD  = 40;
  localparam int WIN   = 200;
  localparam int ADDR  = 30;
  localparam int ST    = 16;
  localparam logic [7:0] CLR = dmb_pkg::CMD_CLEAR_FAULTS;
  localparam logic [7:0] CLM = dmb_pkg::CMD_CLAIM_CTL;
  logic                    mclk, nrst, lclk, on_off_n, module_present, input_ok;
  dmb_pkg::dmb_txn_s [1:0] cmd_txn;
  logic [1:0]              cmd_stb, cmd_ready, wr_active, alert_o, alert_oe;
  logic [7:0]              own_status_rd, fault_live, opst_live, fault_reg, cmd_code;
  dmb_pkg::dmb_stage_s     stage;
  logic [15:0]             bus_v_mv, set_v_mv;
  logic [6:0]              addr_sel, dev_addr;
  logic                    host_v_set, addr_resolved, out_en, restart_ok;
  logic                    cmd_valid, cmd_bus;
  logic [8:0]              last_cmd;
  int                      miscompares;
  int                      check_count;

  always #20 mclk = ~mclk;
  always #3 lclk = ~lclk;
  always @(posedge mclk or negedge nrst)
    if (!nrst)
      last_cmd <= '0;
    else if (cmd_valid)
      last_cmd <= {cmd_bus, cmd_code};

  dmb_ctrl #(.RETRY_CYC(RETRY), .HOLD_CYC(HOLD), .WINDOW_CYC(WIN), .ADDR_CYC(ADDR))
  dmb_ctrl_inst (
    .mclk(mclk), .nrst(nrst), .lclk(lclk), .cmd_txn(cmd_txn), .cmd_stb(cmd_stb),
    .cmd_ready(cmd_ready), .wr_active(wr_active), .own_status_rd(own_status_rd),
    .on_off_n(on_off_n), .module_present(module_present), .input_ok(input_ok),
    .stage(stage), .fault_live(fault_live), .opst_live(opst_live), .bus_v_mv(bus_v_mv),
    .set_v_mv(set_v_mv), .host_v_set(host_v_set), .addr_sel(addr_sel),
    .dev_addr(dev_addr), .addr_resolved(addr_resolved), .alert_o(alert_o),
    .alert_oe(alert_oe), .out_en(out_en), .restart_ok(restart_ok),
    .fault_reg(fault_reg), .cmd_valid(cmd_valid), .cmd_bus(cmd_bus), .cmd_code(cmd_code));

  dmb_host_model dmb_host_model_inst (
    .lclk(lclk), .cmd_ready(cmd_ready), .cmd_txn(cmd_txn), .cmd_stb(cmd_stb),
    .wr_active(wr_active));

  function automatic logic [6:0] exp_addr(input logic [6:0] sel, input logic done);
    return done ? sel : (sel & dmb_pkg::ADDR_DFLT_MASK);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    miscompares += dmb_host_model_inst.timeouts;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // shutdown pulse on trip k: 0 overvoltage, 1 overcurrent, 2 overtemperature
  task automatic trip(input int k, input logic latch);
    stage[7-k] = 1'b1;
    cyc(2);
    stage[7-k] = 1'b0;
    cyc(RETRY - 4);
    chk("off", 16'h0, out_en);
    cyc(14);
    chk("on", {15'h0, !latch}, out_en);
  endtask

  initial
  begin
    repeat (6000) @(negedge mclk);
    miscompares++;
    end_of_test();
  end

  initial
  begin
    logic [7:0] code;
    logic [8:0] snap;
    mclk = 1'b0;
    lclk = 1'b0;
    nrst = 1'b0;
    on_off_n = 1'b0;
    module_present = 1'b0;
    input_ok = 1'b0;
    stage = '0;
    fault_live = '0;
    host_v_set = 1'b0;
    miscompares = 0;
    check_count = 0;
    void'($urandom(36314));
    opst_live = 8'($urandom);
    addr_sel = 7'($urandom) | 7'h01;
    bus_v_mv = dmb_pkg::BUS_V_LOW_MV + 16'd8000;
    set_v_mv = bus_v_mv + 16'd2000;
    cyc(8);
    nrst = 1'b1;
    cyc(4);
    chk("own", 16'h01, own_status_rd);
    chk("alert", 16'h0, alert_oe);
    // power up into a bus at a different voltage
    module_present = 1'b1;
    input_ok = 1'b1;
    on_off_n = 1'b1;
    cyc(ST);
    chk("out_en", 16'h0, out_en);
    chk("addr", exp_addr(addr_sel, 1'b0), dev_addr);
    chk("alert", 16'h3, alert_oe);
    host_v_set = 1'b1;
    cyc(1);
    host_v_set = 1'b0;
    cyc(ADDR);
    chk("out_en", 16'h1, out_en);
    chk("addr", exp_addr(addr_sel, 1'b1), dev_addr);
    bus_v_mv = set_v_mv;
    dmb_host_model_inst.send(1, CLR, 1'b1);
    cyc(ST);
    chk("alert", 16'h3, alert_oe);
    dmb_host_model_inst.send(0, CLR, 1'b1);
    cyc(ST);
    chk("alert", 16'h0, alert_oe);
    // refusals from the bus without control
    snap = last_cmd;
    dmb_host_model_inst.send(1, 8'h01, 1'b1);
    dmb_host_model_inst.send(1, CLM, 1'b0);
    cyc(ST);
    chk("own", 16'h81, own_status_rd);
    chk("cmd", snap, last_cmd);
    // handover waits for the write on bus 0 to stop
    dmb_host_model_inst.hold_write(0, 1'b1);
    dmb_host_model_inst.send(1, CLM, 1'b1);
    cyc(ST);
    chk("own", 16'ha1, own_status_rd);
    dmb_host_model_inst.hold_write(0, 1'b0);
    cyc(ST);
    chk("own", 16'hd4, own_status_rd);
    chk("alert", 16'h3, alert_oe);
    dmb_host_model_inst.send(0, CLR, 1'b1);
    cyc(ST);
    chk("alert", 16'h2, alert_oe);
    dmb_host_model_inst.send(1, CLR, 1'b1);
    dmb_host_model_inst.send(1, CLM, 1'b1);
    cyc(ST);
    chk("own", 16'h10, own_status_rd);
    chk("alert", 16'h0, alert_oe);
    for (int i = 0; i < 4; i++)
    begin
      code = 8'($urandom);
      if (code == CLM || code == CLR)
        code = 8'h5a;
      dmb_host_model_inst.send(1, code, 1'b1);
      cyc(ST);
      chk("cmd", {1'b1, code}, last_cmd);
    end
    // overvoltage strikes across a window expiry
    trip(0, 1'b0);
    trip(0, 1'b0);
    cyc(WIN);
    trip(0, 1'b0);
    trip(0, 1'b0);
    trip(0, 1'b1);
    fault_live = 8'($urandom) | 8'h01;
    stage.final_state = 1'b1;
    cyc(ST);
    chk("faults", fault_live, fault_reg);
    code = fault_live;
    fault_live = '0;
    cyc(ST);
    chk("faults", code, fault_reg);
    on_off_n = 1'b0;
    cyc(HOLD / 2);
    on_off_n = 1'b1;
    cyc(ST);
    chk("out_en", 16'h0, out_en);
    on_off_n = 1'b0;
    cyc(HOLD + 4);
    on_off_n = 1'b1;
    cyc(ST);
    chk("out_en", 16'h1, out_en);
    chk("restart", 16'h1, restart_ok);
    chk("faults", 16'h0, fault_reg);
    stage.final_state = 1'b0;
    trip(1, 1'b0);
    stage.oc_latch_cfg = 1'b1;
    trip(1, 1'b1);
    stage.oc_latch_cfg = 1'b0;
    cyc(ST);
    chk("out_en", 16'h1, out_en);
    trip(2, 1'b0);
    // input return while back-biased stays quiet
    dmb_host_model_inst.send(1, CLR, 1'b1);
    cyc(ST);
    chk("alert", 16'h0, alert_oe);
    stage.back_biased = 1'b1;
    input_ok = 1'b0;
    cyc(ST);
    input_ok = 1'b1;
    cyc(ST);
    chk("alert", 16'h0, alert_oe);
    chk("out_en", 16'h1, out_en);
    stage.back_biased = 1'b0;
    // bias loss mid-run restores the default owner
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(4);
    chk("own", 16'h01, own_status_rd);
    end_of_test();
  end
endmodule // dmb_ctrl_tb_top
